//--- shared/ecpp_pkg.sv
// Purpose: constants and carrier types of the extended-capability parallel port
// Assumes: one system clock, host offsets relative to a programmable base
// Notes:   offsets, mode codes and field positions are shared with the bench
package ecpp_pkg;
   // register offsets from the base address
   localparam logic [15:0] OFS_DATA   = 16'h0000;
   localparam logic [15:0] OFS_STATUS = 16'h0001;
   localparam logic [15:0] OFS_CTRL   = 16'h0002;
   localparam logic [15:0] OFS_FIFO   = 16'h0400;
   localparam logic [15:0] OFS_PORT_CONFIG_SECOND  = 16'h0401;
   localparam logic [15:0] OFS_ECR    = 16'h0402;
   // mode field codes
   localparam logic [2:0]  MODE_STD   = 3'h0;
   localparam logic [2:0]  MODE_BIDIR = 3'h1;
   localparam logic [2:0]  MODE_COMPAT_DATA_FIFO_PORT = 3'h2;
   localparam logic [2:0]  MODE_ECP   = 3'h3;
   localparam logic [2:0]  MODE_TEST  = 3'h6;
   localparam logic [2:0]  MODE_CNFG  = 3'h7;
   // field positions
   localparam int          CTRL_STB   = 0;
   localparam int          CTRL_AFD   = 1;
   localparam int          CTRL_INIT  = 2;
   localparam int          CTRL_SLIN  = 3;
   localparam int          CTRL_DIR   = 5;
   localparam int          ECR_MODE   = 5;
   localparam int          TAG_BIT    = 8;
   localparam int          ADDR_FLAG  = 7;
   // reset and fixed read values
   localparam logic [7:0]  DATA_RST   = 8'h00;
   localparam logic [7:0]  CTRL_RST   = 8'h00;
   localparam logic [7:0]  ECR_RST    = 8'h00;
   localparam logic [7:0]  PORT_CONFIG_FIRST_VAL  = 8'h10;
   localparam logic [7:0]  PORT_CONFIG_SECOND_VAL  = 8'h00;
   localparam logic [7:0]  ZERO8      = 8'h00;
   // fifo geometry and service threshold
   localparam int          FIFO_DEPTH = 16;
   localparam logic [4:0]  FIFO_FULL  = 5'h10;
   localparam logic [4:0]  FIFO_THR   = 5'h08;

   typedef enum logic [1:0] {TX_IDLE, TX_SETUP, TX_STROBE, TX_RELEASE} ecpp_tx_t;

   // peripheral status inputs
   typedef struct packed {
      logic busy;
      logic ack_n;
      logic error_n;
      logic select;
      logic fault_n;
   } ecpp_pin_in_t;

   // control line level and enable (enable low = driving)
   typedef struct packed {
      logic strobe_n;
      logic autofeed_line_n;
      logic init_n;
      logic select_in_line_n;
   } ecpp_ctl_t;

   typedef struct packed {
      logic [7:0]                 data;
      logic [7:0]                 ctrl;
      logic [7:3]                 ecr;
      logic [FIFO_DEPTH-1:0][8:0] mem;
      logic [3:0]                 wp;
      logic [3:0]                 rp;
      logic [4:0]                 cnt;
      ecpp_tx_t                   tx;
      logic [8:0]                 cur;
      logic [6:0]                 chan;
      logic [7:0]                 rle;
      logic [7:0]                 rdata;
      logic                       rvalid;
   } ecpp_st_t;
endpackage : ecpp_pkg

//--- src/ecpp_port.sv
// Purpose: host register front end of an extended-capability parallel port
// Assumes: host strobes last one clock; all pins synchronous to clk
// Notes:   forward address/run-length and data queue with hardware strobes

module ecpp_port
   import ecpp_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic [15:0]  base_addr,
   input  wire logic         function_selection,
   input  wire logic [15:0]  host_addr,
   input  wire logic         host_rd,
   input  wire logic         host_wr,
   input  wire logic [7:0]   host_wdata,
   output logic      [7:0]   host_rdata,
   output logic              host_rvalid,
   input  wire logic [7:0]   pd_in,
   output logic      [7:0]   pd_out,
   output logic              pd_oe_n,
   input  wire ecpp_pin_in_t pin_in,
   output ecpp_ctl_t         ctl_out,
   output ecpp_ctl_t         ctl_oe_n,
   output logic              fifo_service,
   output logic      [6:0]   channel_addr,
   output logic      [7:0]   rle_repeat
);
   ecpp_st_t    st_reg;
   ecpp_st_t    st_next;
   logic [15:0] ofs;
   logic [2:0]  mode;
   logic        dir_eff;
   logic        fifo_full;
   logic        fifo_empty;
   logic        push;
   logic        pop;
   logic [8:0]  push_word;
   ecpp_ctl_t   ctl_lvl;

   // offset from the programmable base
   // base relative decode
   assign ofs = 16'(host_addr - base_addr);

   // mode forced to standard without function select
   // mode field of the extended control
   assign mode = function_selection ? st_reg.ecr[7:ECR_MODE] : MODE_STD;

   // direction only counts outside the two standard modes
   assign dir_eff = st_reg.ctrl[CTRL_DIR] && (mode != MODE_STD) && (mode != MODE_COMPAT_DATA_FIFO_PORT);

   // fifo state flags and threshold service level
   assign fifo_full    = (st_reg.cnt == FIFO_FULL);
   assign fifo_empty   = (st_reg.cnt == 5'h00);
   assign fifo_service = (mode == MODE_ECP) && !dir_eff && ((FIFO_FULL - st_reg.cnt) >= FIFO_THR);

   // push decode for the command and data ports of the ecp mode
   // reverse use of the command port is undefined, so ignored
   always_comb begin
      push      = 1'b0;
      push_word = 9'h000;
      if (host_wr && (mode == MODE_ECP) && !dir_eff && !fifo_full) begin
         // command byte tagged as address or run-length
         if (ofs == OFS_DATA) begin
            push      = 1'b1;
            push_word = {1'b1, host_wdata};
         end else if (ofs == OFS_FIFO) begin
            push      = 1'b1;
            push_word = {1'b0, host_wdata};
         end
      end
   end

   // byte leaves the queue at the end of its handshake
   assign pop = (st_reg.tx == TX_RELEASE) && !pin_in.busy;

   // next-state logic of the whole port
   always_comb begin
      st_next        = st_reg;
      st_next.rvalid = 1'b0;
      // register writes
      if (host_wr) begin
         // status offset absent here: writes have no effect
         if (ofs == OFS_DATA && mode != MODE_ECP) begin
            st_next.data = host_wdata;
         end
         if (ofs == OFS_CTRL) begin
            st_next.ctrl = host_wdata;
         end
         if (ofs == OFS_ECR && function_selection) begin
            st_next.ecr = host_wdata[7:3];
         end
      end
      // register reads, answered one clock later
      if (host_rd) begin
         st_next.rvalid = 1'b1;
         st_next.rdata  = ZERO8;
         case (ofs)
            OFS_DATA:   st_next.rdata = pd_in;
            OFS_STATUS: st_next.rdata = {!pin_in.busy, pin_in.ack_n, pin_in.error_n,
                                         pin_in.select, pin_in.fault_n, 3'h0};
            OFS_CTRL:   st_next.rdata = st_reg.ctrl;
            OFS_FIFO:   st_next.rdata = (mode == MODE_CNFG) ? PORT_CONFIG_FIRST_VAL : ZERO8;
            OFS_PORT_CONFIG_SECOND:  st_next.rdata = (mode == MODE_CNFG) ? PORT_CONFIG_SECOND_VAL : ZERO8;
            OFS_ECR: begin
               if (function_selection) begin
                  st_next.rdata = {st_reg.ecr, fifo_service, fifo_full, fifo_empty};
               end
            end
            default:    st_next.rdata = ZERO8;
         endcase
      end
      case (st_reg.tx)
         TX_IDLE: begin
            if (mode == MODE_ECP && !dir_eff && !fifo_empty) begin
               st_next.cur = st_reg.mem[st_reg.rp];
               st_next.tx  = TX_SETUP;
            end
         end
         TX_SETUP:   st_next.tx = TX_STROBE;
         TX_STROBE: begin
            if (pin_in.busy) begin
               st_next.tx = TX_RELEASE;
            end
         end
         TX_RELEASE: begin
            if (!pin_in.busy) begin
               st_next.tx = TX_IDLE;
               if (st_reg.cur[TAG_BIT]) begin
                  if (st_reg.cur[ADDR_FLAG]) begin
                     st_next.chan = st_reg.cur[6:0];
                  end else begin
                     st_next.rle = 8'({1'b0, st_reg.cur[6:0]} + 8'h01);
                  end
               end
            end
         end
         default:    st_next.tx = TX_IDLE;
      endcase
      if (push) begin
         st_next.mem[st_reg.wp] = push_word;
         st_next.wp             = 4'(st_reg.wp + 4'h1);
      end
      if (pop) begin
         st_next.rp = 4'(st_reg.rp + 4'h1);
      end
      st_next.cnt = 5'(st_reg.cnt + {4'h0, push} - {4'h0, pop});
      // fifo held in reset in standard mode
      if (mode == MODE_STD) begin
         st_next.wp  = 4'h0;
         st_next.rp  = 4'h0;
         st_next.cnt = 5'h00;
         st_next.tx  = TX_IDLE;
      end
   end

   // state register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg      <= '0;
         st_reg.data <= DATA_RST;
         st_reg.ctrl <= CTRL_RST;
         st_reg.ecr  <= ECR_RST[7:3];
         st_reg.rle  <= 8'h01;
         st_reg.tx   <= TX_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // host answer and decoded command outputs
   assign host_rdata   = st_reg.rdata;
   assign host_rvalid  = st_reg.rvalid;
   assign channel_addr = st_reg.chan;
   assign rle_repeat   = st_reg.rle;

   // data lines: queued byte during a handshake, else the latch
   // standard data drive
   assign pd_out  = (st_reg.tx != TX_IDLE) ? st_reg.cur[7:0] : st_reg.data;
   assign pd_oe_n = dir_eff;

   // control line levels, handshake owns strobe and autofeed
   always_comb begin
      ctl_lvl.strobe_n         = !st_reg.ctrl[CTRL_STB];
      ctl_lvl.autofeed_line_n  = !st_reg.ctrl[CTRL_AFD];
      ctl_lvl.init_n           = st_reg.ctrl[CTRL_INIT];
      ctl_lvl.select_in_line_n = !st_reg.ctrl[CTRL_SLIN];
      if (st_reg.tx != TX_IDLE) begin
         ctl_lvl.strobe_n        = (st_reg.tx != TX_STROBE);
         ctl_lvl.autofeed_line_n = !st_reg.cur[TAG_BIT]; // low marks a command
      end
   end

   // open-collector in standard mode: drive only the low level
   assign ctl_out  = ctl_lvl;
   assign ctl_oe_n = (mode == MODE_STD) ? ctl_lvl : '0;

   // checks
   sequence s_strobe_taken;
      (st_reg.tx == TX_STROBE) && pin_in.busy;
   endsequence

   sequence s_strobe_released;
      (st_reg.tx == TX_RELEASE) && ctl_out.strobe_n;
   endsequence

   chk_status_bits: assert property (
      @(posedge clk) disable iff (!reset_n)
      host_rd && (ofs == OFS_STATUS) |=> host_rvalid &&
         (host_rdata[7:3] == {!$past(pin_in.busy), $past(pin_in.ack_n),
          $past(pin_in.error_n), $past(pin_in.select), $past(pin_in.fault_n)}))
      else $error("status read does not match input lines");

   chk_status_ro: assert property (
      @(posedge clk) disable iff (!reset_n)
      host_wr && (ofs == OFS_STATUS) |=> $stable(st_reg.ctrl) && $stable(st_reg.data))
      else $error("status write changed a register");

   chk_data_drive: assert property (
      @(posedge clk) disable iff (!reset_n)
      host_wr && (ofs == OFS_DATA) && (mode == MODE_STD) && function_selection
         |=> (pd_out == $past(host_wdata)) && !pd_oe_n)
      else $error("standard data write not driven");

   chk_dir_float: assert property (
      @(posedge clk) disable iff (!reset_n)
      (mode == MODE_BIDIR) && st_reg.ctrl[CTRL_DIR] |-> pd_oe_n)
      else $error("data drivers active with direction set");

   chk_data_live: assert property (
      @(posedge clk) disable iff (!reset_n)
      host_rd && (ofs == OFS_DATA) |=> host_rdata == $past(pd_in))
      else $error("data read is not the line level");

   chk_afifo_push: assert property (
      @(posedge clk) disable iff (!reset_n)
      host_wr && (ofs == OFS_DATA) && (mode == MODE_ECP) && !dir_eff && !fifo_full
         ##1 (mode == MODE_ECP)
         |-> st_reg.mem[$past(st_reg.wp)] == {1'b1, $past(host_wdata)})
      else $error("command byte not queued with its tag");

   chk_fifo_reset: assert property (
      @(posedge clk) disable iff (!reset_n)
      (mode == MODE_STD) [*2] |-> fifo_empty && (st_reg.tx == TX_IDLE))
      else $error("fifo not held in reset in standard mode");

   chk_strobe_seq: assert property (
      @(posedge clk) disable iff (!reset_n)
      (mode == MODE_ECP) ##0 s_strobe_taken |=> s_strobe_released)
      else $error("strobe not released after busy");

   chk_send_start: assert property (
      @(posedge clk) disable iff (!reset_n)
      (st_reg.tx == TX_IDLE) && (mode == MODE_ECP) && !dir_eff && !fifo_empty
         |=> ##1 !ctl_out.strobe_n || (mode != MODE_ECP))
      else $error("queued byte not strobed out");

   chk_chan_addr: assert property (
      @(posedge clk) disable iff (!reset_n)
      pop && st_reg.cur[TAG_BIT] && st_reg.cur[ADDR_FLAG]
         |=> channel_addr == $past(st_reg.cur[6:0]))
      else $error("channel address not captured");

   chk_rle_count: assert property (
      @(posedge clk) disable iff (!reset_n)
      pop && st_reg.cur[TAG_BIT] && !st_reg.cur[ADDR_FLAG]
         |=> rle_repeat == 8'({1'b0, $past(st_reg.cur[6:0])} + 8'h01))
      else $error("repeat count not count plus one");

   chk_mode_gate: assert property (
      @(posedge clk) disable iff (!reset_n)
      host_rd && (ofs == OFS_ECR) && !function_selection |=> host_rdata == ZERO8)
      else $error("extended control visible without function select");

   // handshake end: busy seen low while the strobe is released
   sequence s_release_done;
      (st_reg.tx == TX_RELEASE) && !pin_in.busy;
   endsequence

   chk_pop_idle: assert property (
      @(posedge clk) disable iff (!reset_n)
      s_release_done |=> (st_reg.tx == TX_IDLE))
      else $error("handshake did not return to idle");

   chk_rvalid_pulse: assert property (
      @(posedge clk) disable iff (!reset_n)
      host_rvalid == $past(host_rd))
      else $error("read answer not one clock after the strobe");

   chk_ctl_open_coll: assert property (
      @(posedge clk) disable iff (!reset_n)
      (mode == MODE_STD) |-> ((4'(~ctl_oe_n) & 4'(ctl_out)) == 4'h0))
      else $error("control pin driven high in standard mode");

   chk_ctl_push_pull: assert property (
      @(posedge clk) disable iff (!reset_n)
      (mode != MODE_STD) |-> (4'(ctl_oe_n) == 4'h0))
      else $error("control pin not driven outside standard mode");

   chk_mode_forced: assert property (
      @(posedge clk) disable iff (!reset_n)
      !function_selection |-> (mode == MODE_STD))
      else $error("extended mode active without function select");

   chk_fifo_bound: assert property (
      @(posedge clk) disable iff (!reset_n)
      st_reg.cnt <= FIFO_FULL)
      else $error("fifo count above sixteen");

   chk_full_write: assert property (
      @(posedge clk) disable iff (!reset_n)
      fifo_full && host_wr && (ofs == OFS_FIFO) && !pop
         |=> $stable(st_reg.wp) || (mode == MODE_STD))
      else $error("write accepted into a full fifo");

   chk_service_level: assert property (
      @(posedge clk) disable iff (!reset_n)
      fifo_service |-> (mode == MODE_ECP) && (st_reg.cnt <= FIFO_FULL - FIFO_THR))
      else $error("service flag without free space");

endmodule // ecpp_port

//--- tb/ecpp_periph.sv
// Purpose: cable-side peripheral, answers hardware strobes with busy
// Assumes: busy rises on the clock edge that first sees strobe low
// Notes:   stall holds busy high so the queue backs up
module ecpp_periph
   import ecpp_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire ecpp_ctl_t    ctl_out,
   input  wire logic [7:0]   pd_out,
   input  wire logic         stall,
   input  wire logic [3:0]   stat_lines,
   output ecpp_pin_in_t      pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       busy_reg;
   logic [8:0] got[$];   // {autofeed level, byte} per strobe

   // status lines: busy, ack, error, select, fault
   assign pin_in = {busy_reg, stat_lines};

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_reg <= 1'b0;
      end else if (!ctl_out.strobe_n && !busy_reg) begin
         busy_reg <= 1'b1;
         got.push_back({ctl_out.autofeed_line_n, pd_out});
      end else if (ctl_out.strobe_n && busy_reg && !stall) begin
         busy_reg <= 1'b0;   // slow answer while stalled
      end
   end
endmodule // ecpp_periph

//--- tb/tb_top.sv
// Purpose: self-checking bench of the parallel port register front end
// Assumes: host strobes one clock wide, driven at the falling edge
// Notes:   the peripheral drives 3c whenever the port releases the data lines
module tb_top
   import ecpp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic         clk;
   logic         reset_n;
   logic [15:0]  base_addr;
   logic         fsel;
   logic [15:0]  host_addr;
   logic         host_rd;
   logic         host_wr;
   logic [7:0]   host_wdata;
   logic [7:0]   host_rdata;
   logic         host_rvalid;
   logic [7:0]   pd_in;
   logic [7:0]   pd_out;
   logic         pd_oe_n;
   ecpp_pin_in_t pin_in;
   ecpp_ctl_t    ctl_out;
   ecpp_ctl_t    ctl_oe_n;
   logic         fifo_service;
   logic [6:0]   channel_addr;
   logic [7:0]   rle_repeat;
   logic         stall;
   logic [3:0]   stat_lines;
   int           num_errors;
   int           comparisons;
   int           cycles;

   // wire level of the data lines
   assign pd_in = pd_oe_n ? 8'h3c : pd_out;

   ecpp_port i_ecpp_port (.clk(clk), .reset_n(reset_n), .base_addr(base_addr),
      .function_selection(fsel), .host_addr(host_addr), .host_rd(host_rd),
      .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
      .host_rvalid(host_rvalid), .pd_in(pd_in), .pd_out(pd_out), .pd_oe_n(pd_oe_n),
      .pin_in(pin_in), .ctl_out(ctl_out), .ctl_oe_n(ctl_oe_n),
      .fifo_service(fifo_service), .channel_addr(channel_addr),
      .rle_repeat(rle_repeat));
   ecpp_periph i_ecpp_periph (.clk(clk), .reset_n(reset_n), .ctl_out(ctl_out),
      .pd_out(pd_out), .stall(stall), .stat_lines(stat_lines), .pin_in(pin_in));

   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 50000) begin
         num_errors++;
         summarize();
      end
   end

   task automatic summarize();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one host write cycle
   task automatic wr(input logic [15:0] ofs, input logic [7:0] d);
      @(negedge clk);
      host_addr = base_addr + ofs;
      host_wdata = d;
      host_wr = 1'b1;
      @(negedge clk);
      host_wr = 1'b0;
   endtask

   // one host read cycle, answer taken one clock later
   task automatic rdchk(input string what, input logic [15:0] ofs, input logic [7:0] exp,
                        input logic [7:0] mask = 8'hff);
      @(negedge clk);
      host_addr = base_addr + ofs;
      host_rd = 1'b1;
      @(negedge clk);
      host_rd = 1'b0;
      chk("rvalid", 16'h1, {15'h0, host_rvalid});
      chk(what, {8'h0, exp & mask}, {8'h0, host_rdata & mask});
   endtask

   task automatic mode(input logic [2:0] m);
      wr(OFS_ECR, {m, 5'h00});
   endtask

   task automatic wait_got(input int n);
      for (int i = 0; i < 2000 && i_ecpp_periph.got.size() < n; i++)
         @(negedge clk);
      repeat (6) @(negedge clk);
      chk("bytes sent", n[15:0], i_ecpp_periph.got.size());
   endtask

   task automatic t_reset();
      rdchk("ctrl reset", OFS_CTRL, CTRL_RST);
      rdchk("ecr hidden", OFS_ECR, ZERO8);
      mode(MODE_ECP);
      fsel = 1'b1;
      rdchk("ecr after select", OFS_ECR, 8'h01);
   endtask

   task automatic t_status();
      stat_lines = 4'ha;
      rdchk("status", OFS_STATUS, 8'hd0, 8'hf8);
      wr(OFS_STATUS, 8'h00);
      stat_lines = 4'h5;
      rdchk("status ro", OFS_STATUS, 8'ha8, 8'hf8);
   endtask

   task automatic t_data();
      wr(OFS_CTRL, 8'h20);
      wr(OFS_DATA, 8'ha5);
      chk("drive std", 16'h0, {15'h0, pd_oe_n});
      rdchk("data std", OFS_DATA, 8'ha5);
      mode(MODE_BIDIR);
      chk("drive bidir", 16'h1, {15'h0, pd_oe_n});
      rdchk("data lines", OFS_DATA, 8'h3c);
      wr(OFS_CTRL, 8'h00);
      chk("drive fwd", 16'h0, {15'h0, pd_oe_n});
      wr(OFS_CTRL, 8'h20);
      mode(MODE_COMPAT_DATA_FIFO_PORT);
      chk("drive compat_data_fifo_port", 16'h0, {15'h0, pd_oe_n});
      wr(OFS_CTRL, 8'h00);
   endtask

   task automatic t_ctl();
      mode(MODE_STD);
      wr(OFS_CTRL, 8'h05);
      chk("ctl levels", 16'h7, {12'h0, ctl_out});
      chk("ctl open coll", 16'h7, {12'h0, ctl_oe_n});
      mode(MODE_BIDIR);
      chk("ctl push pull", 16'h0, {12'h0, ctl_oe_n});
      wr(OFS_CTRL, 8'h00);
      mode(MODE_CNFG);
      rdchk("cnfg a", OFS_FIFO, PORT_CONFIG_FIRST_VAL);
      rdchk("cnfg b", OFS_PORT_CONFIG_SECOND, PORT_CONFIG_SECOND_VAL);
      mode(MODE_STD);
      rdchk("fifo std", OFS_FIFO, ZERO8);
      rdchk("unmapped", 16'h0003, ZERO8);
   endtask

   task automatic t_ecp();
      mode(MODE_ECP);
      wr(OFS_CTRL, 8'h00);
      i_ecpp_periph.got.delete();
      wr(OFS_DATA, 8'h85);
      wr(OFS_DATA, 8'h03);
      wr(OFS_FIFO, 8'h5a);
      wait_got(3);
      chk("addr byte", 16'h085, i_ecpp_periph.got[0]);
      chk("rle byte", 16'h003, i_ecpp_periph.got[1]);
      chk("data byte", 16'h15a, i_ecpp_periph.got[2]);
      chk("channel", 16'h05, {9'h0, channel_addr});
      chk("repeat", 16'h04, {8'h0, rle_repeat});
   endtask

   task automatic t_fill();
      stall = 1'b1;
      i_ecpp_periph.got.delete();
      for (int i = 0; i < FIFO_DEPTH + 1; i++)
         wr(OFS_FIFO, 8'h10 + i[7:0]);
      rdchk("ecr full", OFS_ECR, 8'h62);
      chk("service full", 16'h0, {15'h0, fifo_service});
      rdchk("status busy", OFS_STATUS, {1'b0, stat_lines, 3'h0}, 8'hf8);
      stall = 1'b0;
      wait_got(FIFO_DEPTH);
      chk("last byte", 16'h11f, i_ecpp_periph.got[FIFO_DEPTH-1]);
      rdchk("ecr empty", OFS_ECR, 8'h65);
      chk("service empty", 16'h1, {15'h0, fifo_service});
   endtask

   // reset, then each scenario in turn
   initial begin
      reset_n = 1'b0;
      base_addr = 16'h0278;
      fsel = 1'b0;
      host_addr = 16'h0000;
      host_rd = 1'b0;
      host_wr = 1'b0;
      host_wdata = 8'h00;
      stall = 1'b0;
      stat_lines = 4'h0;
      num_errors = 0;
      comparisons = 0;
      cycles = 0;
      repeat (20) @(negedge clk);
      reset_n = 1'b1;
      t_reset();
      t_status();
      t_data();
      t_ctl();
      t_ecp();
      t_fill();
      summarize();
   end
endmodule // tb_top
